// File: hdl/dsc_top.sv
// Module: downstream port general control bits 10..0 and the capability fields they drive
//
// Functional notes
// - Bit 10 drives the latch sensor present capability field.
// - Bit 9 drives the power controller present capability field.
// - Bit 8 drives the attention button present capability field.
// - Bit 7 drives the slot implemented bit of express capabilities.
// - Bit 7 defaults from the port strap input level after reset.
// - Bit 6 enables use of the power fault input pin.
// - Bit 5 drives the interlock present capability field.
// - Bit 4 drives the link active reporting capable field.
// - Bit 4 also drives the surprise down reporting capable field.
// - Bit 2 reads zero and ignores writes.
// - Bit 1 high disables the downstream reference clock output.
// - Bit 0 selects presence source: card pin or receiver detect.
// - Bit 0 defaults to inverse of port strap input after reset.
// - Fundamental reset clears fields, then EEPROM loads them when present.
// - Register sits at configuration offset D4h.
`timescale 1ns/100ps
module dsc_top
  import dsc_pkg::*;
(
  // Clock and fundamental reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Configuration space access
  input  wire logic                  cfg_wr,
  input  wire logic [DSC_CFG_AW-1:0] cfg_addr,
  input  wire logic [31:0]           cfg_wdata,
  input  wire logic [3:0]            cfg_be,
  output logic                       cfg_hit,
  output logic [31:0]                cfg_rdata,
  // Serial EEPROM loader
  input  wire logic                  rom_present,
  input  wire logic                  rom_done,
  input  wire logic                  rom_load,
  input  wire logic [10:0]           rom_data,
  // Pins
  input  wire logic                  port_strap_input,
  input  wire logic                  card_present_pin,
  input  wire logic                  power_fault_pin,
  input  wire logic                  refclk_in,
  output logic                       downstream_refclk_out,
  output logic                       downstream_refclk_oe,
  // Link status
  input  wire logic                  rx_detected,
  // Capability fields
  output logic                       cap_latch_sensor_field,
  output logic                       cap_power_ctrl_field,
  output logic                       cap_attn_button_field,
  output logic                       cap_slot_implemented_field,
  output logic                       cap_interlock_field,
  output logic                       cap_link_active_report_field,
  output logic                       cap_surprise_down_report_field,
  output logic                       slot_present,
  output logic                       load_done
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  logic strap_s;
  logic card_present_pin_s;
  logic pfault_s;

  dsc_sync2 u_sync_strap (.clk(clk), .rst(rst), .d_in(port_strap_input), .q_out(strap_s));
  dsc_sync2 u_sync_card_present_pin (.clk(clk), .rst(rst), .d_in(card_present_pin), .q_out(card_present_pin_s));
  dsc_sync2 u_sync_pflt  (.clk(clk), .rst(rst), .d_in(power_fault_pin),  .q_out(pfault_s));

  // ----------------------------------------------------------------
  // Register core access path
  // ----------------------------------------------------------------
  dsc_cfg_if cfg ();

  assign cfg.wr    = cfg_wr;
  assign cfg.addr  = cfg_addr;
  assign cfg.wdata = cfg_wdata;
  assign cfg.be    = cfg_be;
  assign cfg_hit   = cfg.hit;
  assign cfg_rdata = cfg.rdata;

  logic [10:0] ctl;

  dsc_regs u_regs (
    .clk         (clk),
    .rst         (rst),
    .bus         (cfg),
    .strap_s     (strap_s),
    .rom_present (rom_present),
    .rom_done    (rom_done),
    .rom_load    (rom_load),
    .rom_data    (rom_data),
    .ctl         (ctl),
    .load_done   (load_done)
  );

  // ----------------------------------------------------------------
  // Derived capability fields, straight from the stored bits
  // ----------------------------------------------------------------
  // Combinational so a write is visible on the very next read
  assign cap_latch_sensor_field         = ctl[DSC_B_LATCH];
  assign cap_power_ctrl_field           = ctl[DSC_B_PWRCTL];
  assign cap_attn_button_field          = ctl[DSC_B_ATTN];
  assign cap_slot_implemented_field     = ctl[DSC_B_SLOT];
  assign cap_interlock_field            = ctl[DSC_B_ILOCK];
  assign cap_link_active_report_field   = ctl[DSC_B_LINKACT];
  assign cap_surprise_down_report_field = ctl[DSC_B_LINKACT];

  // ----------------------------------------------------------------
  // Presence source and reference clock gating
  // ----------------------------------------------------------------
  wire pfault_used = ctl[DSC_B_PFIP] & pfault_s;
  wire refclk_en   = ~ctl[DSC_B_REFDIS] & ~pfault_used;

  assign slot_present = ctl[DSC_B_RXDET] ? rx_detected : card_present_pin_s;

  // The clock itself is gated, not retimed; the enable is glitch-free from a flop domain
  assign downstream_refclk_out = refclk_in & refclk_en;
  assign downstream_refclk_oe  = refclk_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_refclk_disable: assert property (@(posedge clk) disable iff (rst)
    ctl[DSC_B_REFDIS] |-> !downstream_refclk_oe)
    else $error("Reference clock output enabled while disabled");

  a_presence_mux: assert property (@(posedge clk) disable iff (rst)
    slot_present == (ctl[DSC_B_RXDET] ? rx_detected : card_present_pin_s))
    else $error("Presence source mismatch");

  a_sdown_follow: assert property (@(posedge clk) disable iff (rst)
    cap_surprise_down_report_field == cfg_rdata[DSC_B_LINKACT]
    || !cfg_hit)
    else $error("Surprise down field differs from bit 4");

  a_pfault_gate: assert property (@(posedge clk) disable iff (rst)
    (pfault_s && ctl[DSC_B_PFIP]) |-> !downstream_refclk_oe)
    else $error("Power fault did not gate the reference clock");

  a_cap_follow: assert property (@(posedge clk) disable iff (rst)
    cap_latch_sensor_field == ctl[DSC_B_LATCH] && cap_power_ctrl_field == ctl[DSC_B_PWRCTL]
    && cap_attn_button_field == ctl[DSC_B_ATTN] && cap_interlock_field == ctl[DSC_B_ILOCK]
    && cap_slot_implemented_field == ctl[DSC_B_SLOT])
    else $error("Capability field does not follow stored bit");

  // Ties the link active and interlock fields to what software reads back, so a swapped bit shows
  a_link_follow: assert property (@(posedge clk) disable iff (rst)
    cfg_hit |-> cap_link_active_report_field == cfg_rdata[DSC_B_LINKACT]
    && cap_interlock_field == cfg_rdata[DSC_B_ILOCK])
    else $error("Link or interlock field differs from stored bit");

  a_refclk_on: assert property (@(posedge clk) disable iff (rst)
    (!ctl[DSC_B_REFDIS] && !ctl[DSC_B_PFIP]) |-> downstream_refclk_oe)
    else $error("Reference clock output disabled while enabled");

  a_refclk_gated: assert property (@(posedge clk) disable iff (rst)
    !downstream_refclk_oe |-> !downstream_refclk_out)
    else $error("Reference clock toggles while output disabled");

endmodule

// Module: storage, reset defaults, EEPROM load and config decode for bits 10..0
module dsc_regs
  import dsc_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Configuration access
  dsc_cfg_if.core    bus,
  // Sources of default and load values
  input  wire logic  strap_s,
  input  wire logic  rom_present,
  input  wire logic  rom_done,
  input  wire logic  rom_load,
  input  wire logic [10:0] rom_data,
  // Stored bits and status
  output logic [10:0] ctl,
  output logic        load_done
);
  dsc_state_t  state_ff;
  dsc_state_t  nxt_state;
  logic [10:0] ctl_ff;
  logic [10:0] nxt_ctl;
  logic        settle_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire hit      = (bus.addr == DSC_GEN_CTRL_OFS);
  wire wr_lo    = bus.wr & hit & bus.be[0] & (state_ff == DSC_ST_RUN);
  wire wr_hi    = bus.wr & hit & bus.be[1] & (state_ff == DSC_ST_RUN);
  wire [10:0] lane_m  = {{3{wr_hi}}, {8{wr_lo}}} & DSC_WR_MASK;
  wire [10:0] wr_val  = (ctl_ff & ~lane_m) | (bus.wdata[10:0] & lane_m);
  wire [10:0] rom_val = rom_data & DSC_WR_MASK;
  // Strap defaults: bit 7 follows the strap, bit 0 its inverse
  wire [10:0] strap_val = (ctl_ff & ~11'h0_81)
                        | {3'h0, strap_s, 6'h00, ~strap_s};

  always_comb begin
    nxt_state = state_ff;
    nxt_ctl   = ctl_ff;
    case (state_ff)
      DSC_ST_RESET: begin
        // Synchronisers restart from zero with reset; wait until the strap has crossed
        if (settle_ff) begin
          nxt_state = DSC_ST_STRAP;
        end
      end
      DSC_ST_STRAP: begin
        // Strap sampled after the synchroniser has filled
        nxt_ctl   = strap_val;
        nxt_state = rom_present ? DSC_ST_WAIT_ROM : DSC_ST_RUN;
      end
      DSC_ST_WAIT_ROM: begin
        if (rom_load) begin
          nxt_ctl = rom_val;
        end
        if (rom_done) begin
          nxt_state = DSC_ST_RUN;
        end
      end
      DSC_ST_RUN: begin
        nxt_ctl = wr_val;
      end
      default: begin
        nxt_state = DSC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff  <= DSC_ST_RESET;
      ctl_ff    <= DSC_RST_VAL;
      settle_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ctl_ff    <= nxt_ctl;
      settle_ff <= (state_ff == DSC_ST_RESET);
    end
  end

  assign ctl       = ctl_ff;
  assign load_done = (state_ff == DSC_ST_RUN);
  assign bus.hit   = hit;
  assign bus.rdata = hit ? {DSC_HI_ZERO, ctl_ff} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_released;
    $fell(rst);
  endsequence

  // Two cycles in the reset state, then the strap step
  sequence s_settle_steps;
    state_ff == DSC_ST_RESET ##1 state_ff == DSC_ST_RESET ##1 state_ff == DSC_ST_STRAP;
  endsequence

  sequence s_rom_beat;
    (state_ff == DSC_ST_WAIT_ROM) && rom_load;
  endsequence

  a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    hit |-> bus.rdata[DSC_B_RSVD2] == 1'b0)
    else $error("Reserved bit 2 read nonzero");

  a_strap_default: assert property (@(posedge clk) disable iff (rst)
    (state_ff == DSC_ST_STRAP) |=> (ctl_ff[DSC_B_SLOT] == $past(strap_s)
    && ctl_ff[DSC_B_RXDET] == !$past(strap_s)))
    else $error("Strap default not applied");

  a_write_visible: assert property (@(posedge clk) disable iff (rst)
    (wr_lo && wr_hi) |=> ctl_ff == ($past(bus.wdata[10:0]) & DSC_WR_MASK))
    else $error("Write not reflected in stored bits");

  a_reset_clear: assert property (@(posedge clk)
    $past(rst) |-> ctl_ff == DSC_RST_VAL)
    else $error("Fields not cleared by reset");

  a_release_settle: assert property (@(posedge clk) disable iff (rst)
    s_released |-> s_settle_steps)
    else $error("Strap step not delayed past the synchroniser");

  a_rom_load: assert property (@(posedge clk) disable iff (rst)
    s_rom_beat |=> ctl_ff == ($past(rom_data) & DSC_WR_MASK))
    else $error("EEPROM word not loaded");

  a_load_branch: assert property (@(posedge clk) disable iff (rst)
    (state_ff == DSC_ST_STRAP) |=> (load_done == !$past(rom_present)))
    else $error("Load path does not follow EEPROM presence");

  a_early_write: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && hit && (state_ff == DSC_ST_RESET || (state_ff == DSC_ST_WAIT_ROM && !rom_load)))
    |=> $stable(ctl_ff))
    else $error("Write taken before the load finished");

  a_lane_keep: assert property (@(posedge clk) disable iff (rst)
    (wr_lo && !wr_hi) |=> ctl_ff[10:8] == $past(ctl_ff[10:8]))
    else $error("Unselected byte lane changed");

endmodule

// File: hdl/dsc_pkg.sv
// Package: offsets, bit positions, reset values and codes for the slot configuration bits
package dsc_pkg;

  // ----------------------------------------------------------------
  // Register placement
  // ----------------------------------------------------------------
  localparam logic [11:0] DSC_GEN_CTRL_OFS = 12'h0_0D4;
  localparam int          DSC_CFG_AW       = 12;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DSC_B_LATCH   = 10;
  localparam int DSC_B_PWRCTL  = 9;
  localparam int DSC_B_ATTN    = 8;
  localparam int DSC_B_SLOT    = 7;
  localparam int DSC_B_PFIP    = 6;
  localparam int DSC_B_ILOCK   = 5;
  localparam int DSC_B_LINKACT = 4;
  localparam int DSC_B_DIAG    = 3;
  localparam int DSC_B_RSVD2   = 2;
  localparam int DSC_B_REFDIS  = 1;
  localparam int DSC_B_RXDET   = 0;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  // Writable bits of the low field: everything in 10..0 except bit 2
  localparam logic [10:0] DSC_WR_MASK  = 11'h7_FB;
  localparam logic [10:0] DSC_RST_VAL  = 11'h0_00;
  localparam logic [20:0] DSC_HI_ZERO  = 21'h00_0000;

  // ----------------------------------------------------------------
  // Load sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSC_ST_RESET,
    DSC_ST_STRAP,
    DSC_ST_WAIT_ROM,
    DSC_ST_RUN
  } dsc_state_t;

endpackage

// File: hdl/dsc_cfg_if.sv
// Interface: configuration access path between the top and the register core
`timescale 1ns/100ps
interface dsc_cfg_if;
  import dsc_pkg::*;
  logic                  wr;
  logic [DSC_CFG_AW-1:0] addr;
  logic [31:0]           wdata;
  logic [3:0]            be;
  logic                  hit;
  logic [31:0]           rdata;
  modport core (input wr, addr, wdata, be, output hit, rdata);
  modport src  (output wr, addr, wdata, be, input hit, rdata);
endinterface

// File: hdl/dsc_sync2.sv
// Module: two flip-flop synchroniser for a single level
`timescale 1ns/100ps
module dsc_sync2
  import dsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule

// File: tb/dsc_top_tb_top.sv
// Testbench: config reads and writes, strap defaults, EEPROM load and derived fields
`timescale 1ns/100ps
module dsc_top_tb_top;
  import dsc_pkg::*;
  logic                  clk, rst, cfg_wr, cfg_hit, rom_present, rom_done, rom_load;
  logic [DSC_CFG_AW-1:0] cfg_addr;
  logic [31:0]           cfg_wdata, cfg_rdata;
  logic [3:0]            cfg_be;
  logic [10:0]           rom_data;
  logic                  port_strap_input, card_present_pin, power_fault_pin, refclk_in;
  logic                  downstream_refclk_out, downstream_refclk_oe, rx_detected;
  logic [6:0]            caps;
  logic                  slot_present, load_done;
  int                    err_count, cmp_count, cyc;

  dsc_top i_dsc_top (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .rom_present(rom_present),
    .rom_done(rom_done), .rom_load(rom_load), .rom_data(rom_data),
    .port_strap_input(port_strap_input), .card_present_pin(card_present_pin),
    .power_fault_pin(power_fault_pin), .refclk_in(refclk_in),
    .downstream_refclk_out(downstream_refclk_out), .downstream_refclk_oe(downstream_refclk_oe),
    .rx_detected(rx_detected), .cap_latch_sensor_field(caps[6]), .cap_power_ctrl_field(caps[5]),
    .cap_attn_button_field(caps[4]), .cap_slot_implemented_field(caps[3]),
    .cap_interlock_field(caps[2]), .cap_link_active_report_field(caps[1]),
    .cap_surprise_down_report_field(caps[0]), .slot_present(slot_present), .load_done(load_done)
  );

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is under a hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] d, input logic [3:0] b);
    cfg_addr  = DSC_GEN_CTRL_OFS;
    cfg_wdata = d;
    cfg_be    = b;
    cfg_wr    = 1'b1;
    @(posedge clk);
    #1 cfg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Reads are combinational; sample one edge after the address settles
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    cfg_addr = a;
    @(posedge clk);
    #1;
    chk("rdata", cfg_rdata, exp);
    chk("hit", {31'h0, cfg_hit}, {31'h0, a == DSC_GEN_CTRL_OFS});
  endtask

  // Derived fields follow bits 10,9,8,7,5,4,4 of the stored value
  task automatic chk_caps(input logic [10:0] v);
    chk("caps", {25'h0, caps}, {25'h0, v[10], v[9], v[8], v[7], v[5], v[4], v[4]});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    wait_cyc(8);
    rst = 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (load_done !== 1'b1 && n < 50) begin
      wait_cyc(1);
      n = n + 1;
    end
    chk("load_done", {31'h0, load_done}, 32'h0000_0001);
  endtask

  task print_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    err_count = 0; cmp_count = 0; cyc = 0;
    cfg_wr = 1'b0; cfg_addr = 12'h000; cfg_wdata = 32'h0000_0000; cfg_be = 4'h0;
    rom_present = 1'b0; rom_done = 1'b0; rom_load = 1'b0; rom_data = 11'h000;
    port_strap_input = 1'b1; card_present_pin = 1'b0; power_fault_pin = 1'b0;
    refclk_in = 1'b1; rx_detected = 1'b0;
    do_reset();
    wait_done();
    rd(DSC_GEN_CTRL_OFS, 32'h0000_0080);
    chk_caps(11'h080);
    // All writable ones, reserved bit 2 set as well; bit 3 held at zero
    wr(32'hFFFF_FFF7, 4'hF);
    rd(DSC_GEN_CTRL_OFS, 32'h0000_07F3);
    chk_caps(11'h7F3);
    chk("oe", {31'h0, downstream_refclk_oe}, 32'h0);
    chk("out", {31'h0, downstream_refclk_out}, 32'h0);
    rx_detected = 1'b1;
    wait_cyc(1);
    chk("present", {31'h0, slot_present}, 32'h1);
    rx_detected = 1'b0;
    wait_cyc(1);
    chk("present", {31'h0, slot_present}, 32'h0);
    // Only the fault input enable: clock runs until a fault is seen
    wr(32'h0000_0040, 4'hF);
    chk_caps(11'h040);
    chk("oe", {31'h0, downstream_refclk_oe}, 32'h1);
    chk("out", {31'h0, downstream_refclk_out}, 32'h1);
    power_fault_pin = 1'b1;
    wait_cyc(4);
    chk("oe_pf", {31'h0, downstream_refclk_oe}, 32'h0);
    power_fault_pin = 1'b0;
    card_present_pin = 1'b1;
    wait_cyc(4);
    chk("oe_pf", {31'h0, downstream_refclk_oe}, 32'h1);
    chk("present", {31'h0, slot_present}, 32'h1);
    card_present_pin = 1'b0;
    wait_cyc(4);
    chk("present", {31'h0, slot_present}, 32'h0);
    // Low byte only: bits 10..8 must keep their old zeros
    wr(32'h0000_0722, 4'h1);
    rd(DSC_GEN_CTRL_OFS, 32'h0000_0022);
    chk_caps(11'h022);
    rd(12'h0D8, 32'h0000_0000);
    rd(12'h0D0, 32'h0000_0000);
    // Second reset, strap low, EEPROM present
    port_strap_input = 1'b0;
    rom_present = 1'b1;
    do_reset();
    wait_cyc(4);
    chk("load_done", {31'h0, load_done}, 32'h0);
    rd(DSC_GEN_CTRL_OFS, 32'h0000_0001);
    wr(32'h0000_0002, 4'hF);
    rd(DSC_GEN_CTRL_OFS, 32'h0000_0001);
    // Image keeps bit 3 at zero; bit 2 set in it must not appear
    rom_data = 11'h6F6;
    rom_load = 1'b1;
    wait_cyc(1);
    rom_load = 1'b0;
    rom_done = 1'b1;
    wait_cyc(1);
    rom_done = 1'b0;
    wait_done();
    rd(DSC_GEN_CTRL_OFS, 32'h0000_06F2);
    chk_caps(11'h6F2);
    chk("oe", {31'h0, downstream_refclk_oe}, 32'h0);
    print_verdict();
  end
endmodule
